// [hdl/uart_modem_defines.svh]
// Purpose: Offsets, field positions and reset values of the modem port
// Assumes: Byte addresses on a 32-bit AXI4-Lite register bus
// Notes: Definitions only
`ifndef UART_MODEM_DEFINES_SVH
`define UART_MODEM_DEFINES_SVH

`define UM_OFF_CTRL 8'h00
`define UM_OFF_MSR 8'h04
`define UM_OFF_IRQ_STATUS 8'h08
`define UM_OFF_IRQ_MASK 8'h0c
`define UM_OFF_LINE_STATE 8'h10

`define UM_CTRL_RTS 1
`define UM_CTRL_LOOP 4
`define UM_CTRL_AUTO_RTS 5
`define UM_MSR_RING_EDGE 2
`define UM_MSR_RING 6
`define UM_IRQ_RING 0
`define UM_LS_RTS_ON 0
`define UM_LS_THRESH 1
`define UM_LS_LOOP 2

`define UM_RX_OVERSAMPLE 16
`define UM_RESP_OKAY 2'h0
`define UM_RESP_SLVERR 2'h2
`define UM_CTRL_RESET 8'h00
`define UM_IRQ_MASK_RESET 1'h0

`endif

// [hdl/uart_modem_pkg.sv]
// Purpose: Types shared by the modem port and its bench
// Assumes: 8-bit AXI4-Lite byte address, 32-bit data
// Notes: Numbers live in uart_modem_defines.svh
package uart_modem_pkg;

	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic rts_bit;
		logic loop_en;
		logic auto_rts;
		logic ring_trailing_edge_flag;
		logic ring_evt;
		logic irq_mask;
		logic aw_held;
		logic [7:0] awaddr;
		logic w_held;
		logic [7:0] wdata;
		logic wstrb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [1:0] rresp;
		logic ri_prev;
		logic rclk_prev;
		logic [7:0] rx_cnt;
		logic rx_tick;
		logic rd_prev;
		logic [7:0] pin_data;
		logic pin_oe;
		logic rts_n;
		logic irq;
	} state_t;

endpackage

// [hdl/sync2.sv]
// Purpose: Two-flop synchroniser for a group of pin inputs
// Assumes: Inputs are asynchronous to clk_sys
// Notes: First stage is read only by the second
module sync2 #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_r <= RST;
			q <= RST;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// [hdl/uart_modem_ring_rts_read_port.sv]
// Purpose: Ring indicator status, RTS control, pin read strobes, RX clock
// Assumes: 20 MHz clk_sys, synchronous active-high reset, AXI4-Lite
// Notes: All pins except rx_thresh_stop pass sync2 before use
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`include "uart_modem_defines.svh"

module uart_modem_ring_rts_read_port #(
	parameter int RX_OVERSAMPLE = `UM_RX_OVERSAMPLE
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input uart_modem_pkg::axil_req_t axil_req,
	output uart_modem_pkg::axil_rsp_t axil_rsp,
	input wire logic rclk_in,
	input wire logic ring_ind_n,
	input wire logic rx_thresh_stop,
	input wire logic chip_sel,
	input wire logic read_strobe_low_n,
	input wire logic read_strobe_high,
	input wire logic [2:0] pin_addr,
	output logic [7:0] pin_data,
	output logic pin_data_oe,
	output logic rts_n,
	output logic irq,
	output logic rx_bit_tick
);
	import uart_modem_pkg::*;

	if (RX_OVERSAMPLE < 2 || RX_OVERSAMPLE > 256) begin : g_chk
		$error("RX_OVERSAMPLE must lie in 2..256");
	end

	state_t st;
	state_t n;
	logic [7:0] pins_s;
	logic rclk_s;
	logic ri_n_s;
	logic cs_s;
	logic rdl_n_s;
	logic rdh_s;
	logic [2:0] paddr_s;
	logic rclk_rise;
	logic ring_rise;
	logic rd_act;
	logic rd_start;
	logic [7:0] rd_val;
	logic pin_msr_rd;
	logic axi_rd;
	logic axi_msr_rd;
	logic wr_now;
	logic rd_hit;
	logic [7:0] axi_val;

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers

	sync2 #(
		.W(8),
		.RST(8'h50)
	) u_sync (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.d({rclk_in, ring_ind_n, chip_sel, read_strobe_low_n,
			read_strobe_high, pin_addr}),
		.q(pins_s)
	);

	assign {rclk_s, ri_n_s, cs_s, rdl_n_s, rdh_s, paddr_s} = pins_s;

	////////////////////////////////////////////////////////////////////////
	// Register read view

	function automatic logic [8:0] reg_read(
		input logic [7:0] a,
		input state_t s,
		input logic ri_n,
		input logic thr
	);
		logic [7:0] v;
		logic hit;
		v = 8'h00;
		hit = 1'b1;
		case (a)
			`UM_OFF_CTRL: begin
				v[`UM_CTRL_RTS] = s.rts_bit;
				v[`UM_CTRL_LOOP] = s.loop_en;
				v[`UM_CTRL_AUTO_RTS] = s.auto_rts;
			end
			`UM_OFF_MSR: begin
				v[`UM_MSR_RING] = ~ri_n;
				v[`UM_MSR_RING_EDGE] = s.ring_trailing_edge_flag;
			end
			`UM_OFF_IRQ_STATUS: v[`UM_IRQ_RING] = s.ring_evt;
			`UM_OFF_IRQ_MASK: v[`UM_IRQ_RING] = s.irq_mask;
			`UM_OFF_LINE_STATE: begin
				v[`UM_LS_RTS_ON] = ~s.rts_n;
				v[`UM_LS_THRESH] = thr;
				v[`UM_LS_LOOP] = s.loop_en;
			end
			default: hit = 1'b0;
		endcase
		return {hit, v};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Next state

	assign rclk_rise = rclk_s & ~st.rclk_prev;
	assign ring_rise = ri_n_s & ~st.ri_prev;
	assign rd_act = cs_s & (~rdl_n_s | rdh_s);
	assign rd_start = rd_act & ~st.rd_prev;
	assign pin_msr_rd = rd_start & (8'({paddr_s, 2'b00}) == `UM_OFF_MSR);
	assign axi_rd = axil_req.arvalid & st.arready;
	assign axi_msr_rd = axi_rd & (axil_req.araddr == `UM_OFF_MSR);
	assign wr_now = st.aw_held & st.w_held & ~st.bvalid;
	assign rd_val = 8'(reg_read(8'({paddr_s, 2'b00}), st, ri_n_s,
		rx_thresh_stop));
	assign {rd_hit, axi_val} = reg_read(axil_req.araddr, st, ri_n_s,
		rx_thresh_stop);

	always_comb begin
		n = st;
		n.rx_tick = 1'b0;
		if (rclk_rise) begin
			if (st.rx_cnt == 8'(RX_OVERSAMPLE - 1)) begin
				n.rx_cnt = 8'h00;
				n.rx_tick = 1'b1;
			end else begin
				n.rx_cnt = st.rx_cnt + 8'h01;
			end
		end
		n.rclk_prev = rclk_s;
		n.ri_prev = ri_n_s;

		n.rd_prev = rd_act;
		n.pin_oe = rd_act;
		if (rd_start) begin
			n.pin_data = rd_val;
		end

		if (st.awready & axil_req.awvalid) begin
			n.aw_held = 1'b1;
			n.awaddr = axil_req.awaddr;
		end
		if (st.wready & axil_req.wvalid) begin
			n.w_held = 1'b1;
			n.wdata = axil_req.wdata[7:0];
			n.wstrb0 = axil_req.wstrb[0];
		end
		if (st.bvalid & axil_req.bready) begin
			n.bvalid = 1'b0;
		end
		if (wr_now) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `UM_RESP_OKAY;
			case (st.awaddr)
				`UM_OFF_CTRL: begin
					if (st.wstrb0) begin
						n.rts_bit = st.wdata[`UM_CTRL_RTS];
						n.loop_en = st.wdata[`UM_CTRL_LOOP];
						n.auto_rts = st.wdata[`UM_CTRL_AUTO_RTS];
					end
				end
				`UM_OFF_IRQ_STATUS: begin
					if (st.wstrb0 & st.wdata[`UM_IRQ_RING]) begin
						n.ring_evt = 1'b0;
					end
				end
				`UM_OFF_IRQ_MASK: begin
					if (st.wstrb0) begin
						n.irq_mask = st.wdata[`UM_IRQ_RING];
					end
				end
				`UM_OFF_MSR, `UM_OFF_LINE_STATE: n.bresp = `UM_RESP_OKAY;
				default: n.bresp = `UM_RESP_SLVERR;
			endcase
		end
		n.awready = ~n.aw_held & ~n.bvalid;
		n.wready = ~n.w_held & ~n.bvalid;

		if (st.rvalid & axil_req.rready) begin
			n.rvalid = 1'b0;
		end
		if (axi_rd) begin
			n.rvalid = 1'b1;
			n.rdata = axi_val;
			n.rresp = rd_hit ? `UM_RESP_OKAY : `UM_RESP_SLVERR;
		end
		n.arready = ~n.rvalid;

		if (pin_msr_rd | axi_msr_rd) begin
			n.ring_trailing_edge_flag = 1'b0;
		end
		if (ring_rise) begin
			n.ring_trailing_edge_flag = 1'b1;
			n.ring_evt = 1'b1;
		end
		n.irq = n.ring_evt & n.irq_mask;
		n.rts_n = ~(n.rts_bit & ~n.loop_en
			& ~(n.auto_rts & rx_thresh_stop));
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st <= '0;
			st.rts_bit <= 1'(`UM_CTRL_RESET >> `UM_CTRL_RTS);
			st.irq_mask <= `UM_IRQ_MASK_RESET;
			st.ri_prev <= 1'b1;
			st.rts_n <= 1'b1;
		end else begin
			st <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign axil_rsp = '{
		awready: st.awready,
		wready: st.wready,
		bvalid: st.bvalid,
		bresp: st.bresp,
		arready: st.arready,
		rvalid: st.rvalid,
		rdata: {24'h000000, st.rdata},
		rresp: st.rresp
	};
	assign pin_data = st.pin_data;
	assign pin_data_oe = st.pin_oe;
	assign rts_n = st.rts_n;
	assign irq = st.irq;
	assign rx_bit_tick = st.rx_tick;

	////////////////////////////////////////////////////////////////////////
	// Checks

	a_rx_tick_div: assert property (@(posedge clk_sys) disable iff (sys_rst)
		rclk_rise && st.rx_cnt == 8'(RX_OVERSAMPLE - 1) |=> rx_bit_tick
		&& st.rx_cnt == 8'h00)
		else $error("bit tick missing after full rclk count");

	a_rx_tick_only: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!rclk_rise |=> !rx_bit_tick && $stable(st.rx_cnt))
		else $error("bit tick without rclk edge");

	a_pin_read_data: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		rd_start |=> pin_data_oe && pin_data == $past(rd_val))
		else $error("pin read did not present register");

	a_pin_idle_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!rd_act |=> !pin_data_oe)
		else $error("pin data driven without strobe");

	a_msr_ring_level: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		axi_msr_rd |=> axil_rsp.rvalid
		&& axil_rsp.rdata[`UM_MSR_RING] == !$past(ri_n_s))
		else $error("ring level wrong in status read");

	a_ring_edge_set: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ring_rise |=> st.ring_trailing_edge_flag ##1
		(st.ring_trailing_edge_flag || $past(pin_msr_rd || axi_msr_rd)))
		else $error("ring edge flag not set");

	a_ring_irq: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ring_rise && st.irq_mask && !wr_now |=> irq)
		else $error("enabled ring edge gave no interrupt");

	a_rts_active: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st.rts_bit && !st.loop_en
		&& !(st.auto_rts && $past(rx_thresh_stop)) |-> !rts_n)
		else $error("rts not active with bit set");

	a_rts_forced_off: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!st.rts_bit || st.loop_en |-> rts_n)
		else $error("rts active while cleared or looped");

	a_rts_after_reset: assert property (@(posedge clk_sys)
		sys_rst |=> rts_n && !irq)
		else $error("rts or irq active after reset");

	a_auto_rts_stop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st.auto_rts && rx_thresh_stop && !wr_now |=> rts_n)
		else $error("threshold stop did not lift rts");

	a_msr_read_clear: assert property (@(posedge clk_sys)
		disable iff (sys_rst)
		axi_msr_rd && !ring_rise |=> !st.ring_trailing_edge_flag)
		else $error("status read left ring edge flag set");

endmodule

// [verif/modem_model.sv]
// Purpose: Modem side: ring indicator line and receiver clock bursts
// Assumes: Ring line idles high, as with a pull-up
// Notes: Receiver clock stands still outside bursts
module modem_model (
	input wire logic ring_active,
	input wire logic rclk_go,
	input wire logic [7:0] n_rise,
	output logic ring_ind_n,
	output logic rclk_in
);
	timeunit 1ns;
	timeprecision 1ns;
	logic rclk_r = 1'b0;
	assign ring_ind_n = !ring_active;
	assign rclk_in = rclk_r;
	// Burst of n_rise rising edges, 400 ns period
	always @(posedge rclk_go) begin
		repeat (2 * n_rise) #200 rclk_r = ~rclk_r;
	end
endmodule

// [verif/uart_modem_ring_rts_read_port_tb.sv]
// Purpose: Self-checking bench for the ring, RTS and read port block
// Assumes: 20 MHz clk_sys, AXI4-Lite master tasks
// Notes: Expected values worked out from the register layout
`include "uart_modem_defines.svh"
module uart_modem_ring_rts_read_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import uart_modem_pkg::*;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	axil_req_t req = '0;
	axil_rsp_t rsp;
	logic ring_active = 1'b0;
	logic rclk_go = 1'b0;
	logic rx_thresh_stop = 1'b0;
	logic chip_sel = 1'b0;
	logic strb_lo_n = 1'b1;
	logic strb_hi = 1'b0;
	logic [2:0] pin_addr = 3'h0;
	logic ring_ind_n, rclk_in, pin_data_oe, rts_n, irq, rx_bit_tick;
	logic [7:0] pin_data;
	logic [31:0] d;
	logic [1:0] r;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int ticks = 0;
	always #25 clk_sys = ~clk_sys;
	modem_model i_modem_model (.ring_active(ring_active),
		.rclk_go(rclk_go), .n_rise(8'h20), .ring_ind_n(ring_ind_n),
		.rclk_in(rclk_in));
	uart_modem_ring_rts_read_port i_uart_modem_ring_rts_read_port (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .axil_req(req),
		.axil_rsp(rsp), .rclk_in(rclk_in), .ring_ind_n(ring_ind_n),
		.rx_thresh_stop(rx_thresh_stop), .chip_sel(chip_sel),
		.read_strobe_low_n(strb_lo_n), .read_strobe_high(strb_hi),
		.pin_addr(pin_addr), .pin_data(pin_data),
		.pin_data_oe(pin_data_oe), .rts_n(rts_n), .irq(irq),
		.rx_bit_tick(rx_bit_tick));
	////////////////////////////////////////////////////////////////////
	task automatic final_report;
		if (miscompares == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cycles++;
		if (rx_bit_tick === 1'b1) ticks++;
		if (cycles == 20000) begin
			miscompares++;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] v);
		req.awaddr <= a;
		req.wdata <= v;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
		end while (rsp.bvalid !== 1'b1);
		r = rsp.bresp;
		req.bready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic axr(input logic [7:0] a);
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (rsp.rvalid !== 1'b1);
		d = rsp.rdata;
		r = rsp.rresp;
		req.rready <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		axr(a);
		chk(d, exp);
	endtask
	task automatic pin_rd(input logic hi, input logic [7:0] exp);
		chip_sel <= 1'b1;
		pin_addr <= 3'h1;
		if (hi) strb_hi <= 1'b1;
		else strb_lo_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(32'(pin_data_oe), 32'h1);
		chk(32'(pin_data), 32'(exp));
		chip_sel <= 1'b0;
		strb_hi <= 1'b0;
		strb_lo_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
		chk(32'(pin_data_oe), 32'h0);
	endtask
	task automatic rts_is(input logic [7:0] modem_control_reg, input logic exp);
		axw(`UM_OFF_CTRL, 32'(modem_control_reg));
		repeat (2) @(posedge clk_sys);
		chk(32'(rts_n), 32'(exp));
	endtask
	task automatic ring_pulse;
		ring_active <= 1'b1;
		repeat (4) @(posedge clk_sys);
		ring_active <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk(32'(rts_n), 32'h1);
		rdchk(`UM_OFF_CTRL, 32'h0);
		rts_is(8'h02, 1'b0);
		rx_thresh_stop <= 1'b1;
		rts_is(8'h02, 1'b0);
		rts_is(8'h22, 1'b1);
		rx_thresh_stop <= 1'b0;
		rts_is(8'h22, 1'b0);
		rts_is(8'h12, 1'b1);
		rts_is(8'h02, 1'b0);
		rts_is(8'h00, 1'b1);
		rts_is(8'h02, 1'b0);
		axw(8'h20, 32'h0);
		chk(32'(r), 32'(`UM_RESP_SLVERR));
		rdchk(`UM_OFF_CTRL, 32'h2);
		rdchk(`UM_OFF_LINE_STATE, 32'h1);
		sys_rst <= 1'b1;
		repeat (4) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk(32'(rts_n), 32'h1);
		axw(`UM_OFF_IRQ_MASK, 32'h1);
		chk(32'(r), 32'(`UM_RESP_OKAY));
		rdchk(`UM_OFF_IRQ_MASK, 32'h1);
		ring_active <= 1'b1;
		repeat (4) @(posedge clk_sys);
		rdchk(`UM_OFF_MSR, 32'h40);
		chk(32'(irq), 32'h0);
		ring_active <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk(32'(irq), 32'h1);
		rdchk(`UM_OFF_MSR, 32'h04);
		rdchk(`UM_OFF_MSR, 32'h00);
		rdchk(`UM_OFF_IRQ_STATUS, 32'h1);
		axw(`UM_OFF_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk(32'(irq), 32'h0);
		axw(`UM_OFF_IRQ_MASK, 32'h0);
		ring_pulse();
		chk(32'(irq), 32'h0);
		pin_rd(1'b1, 8'h04);
		pin_rd(1'b0, 8'h00);
		rdchk(8'h20, 32'h0);
		chk(32'(r), 32'(`UM_RESP_SLVERR));
		rclk_go <= 1'b1;
		repeat (300) @(posedge clk_sys);
		chk(32'(ticks), 32'h2);
		final_report();
	end
endmodule
